// ---- logic/rtcc_map.vh ----
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH

// ==========================================================
// register offsets (byte addresses, one word each)
`define RTCC_OFF_CTRL      8'h00
`define RTCC_OFF_MODE      8'h04
`define RTCC_OFF_TIME      8'h08
`define RTCC_OFF_CAL       8'h0c
`define RTCC_OFF_STAT      8'h10
`define RTCC_OFF_SCLR      8'h14
`define RTCC_OFF_IEN       8'h18

// ==========================================================
// bit positions
`define RTCC_CTRL_TIME_REQ 0
`define RTCC_CTRL_CAL_REQ  1
`define RTCC_MODE_HR12     0
`define RTCC_MODE_PERSIAN  1
`define RTCC_ST_ACK        0
`define RTCC_ST_SEC        1
`define RTCC_ST_DATE_ERR   2
`define RTCC_ST_REJECT     3

// ==========================================================
// field ranges of the time and calendar words
`define RTCC_TIM_SEC       6:0
`define RTCC_TIM_MIN       14:8
`define RTCC_TIM_HOUR      21:16
`define RTCC_TIM_PM        22
`define RTCC_CAL_CENT      6:0
`define RTCC_CAL_YEAR      15:8
`define RTCC_CAL_MON       20:16
`define RTCC_CAL_DOW       23:21
`define RTCC_CAL_DATE      29:24

// ==========================================================
// bcd limits
`define RTCC_DIGIT_MAX     4'h9
`define RTCC_ZERO          8'h00
`define RTCC_MS_MAX        8'h59
`define RTCC_HR_MAX        8'h23
`define RTCC_HR12_MAX      8'h12
`define RTCC_ONE           8'h01
`define RTCC_PM_ADJ        8'h12
`define RTCC_PM_CARRY      8'h18
`define RTCC_PM_UNIT       4'h8
`define RTCC_DATE_MAX      8'h31
`define RTCC_MON_MAX       8'h12
`define RTCC_MON_FEB       8'h02
`define RTCC_MON_APR       8'h04
`define RTCC_MON_JUN       8'h06
`define RTCC_MON_SEP       8'h09
`define RTCC_MON_NOV       8'h11
`define RTCC_LEN_SHORT     8'h30
`define RTCC_LEN_FEB       8'h28
`define RTCC_LEN_LEAP      8'h29
`define RTCC_YEAR_MAX      8'h99
`define RTCC_DOW_MIN       3'h1
`define RTCC_DOW_MAX       3'h7
`define RTCC_CENT_LO       8'h19
`define RTCC_CENT_HI       8'h20
`define RTCC_PCENT_LO      8'h13
`define RTCC_PCENT_HI      8'h14

// ==========================================================
// reset values and timing
`define RTCC_TIME_RST      32'h00000000
`define RTCC_CAL_RST       32'h01c10020
`define RTCC_CLK_NS        10
`define RTCC_SEC_MS        1000
`define RTCC_NS_PER_MS     1000000

`endif

// ---- logic/rtcc_entry_check.v ----
`timescale 1ns/1ps
`include "rtcc_map.vh"

// ==========================================================
// range and bcd check of one time word and one calendar word
module rtcc_entry_check (
  input  wire [31:0] timeVal,   // time word to check
  input  wire [31:0] calVal,    // calendar word to check
  input  wire        hour12,    // hour field is in 12-hour form
  input  wire        persian,   // persian century range
  output wire        timeOk,    // time word acceptable
  output wire        calOk,     // calendar word acceptable
  output wire [7:0]  monthLen   // last date of the checked month
);

  function isBcd;
    input [7:0] v;
    isBcd = (v[3:0] <= `RTCC_DIGIT_MAX) && (v[7:4] <= `RTCC_DIGIT_MAX);
  endfunction

  function inRange;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    inRange = isBcd(v) && (v >= lo) && (v <= hi);
  endfunction

  wire [7:0] sec  = {1'b0, timeVal[`RTCC_TIM_SEC]};
  wire [7:0] min  = {1'b0, timeVal[`RTCC_TIM_MIN]};
  wire [7:0] hour = {2'b00, timeVal[`RTCC_TIM_HOUR]};
  wire       pm   = timeVal[`RTCC_TIM_PM];
  wire [7:0] cent = {1'b0, calVal[`RTCC_CAL_CENT]};
  wire [7:0] year = calVal[`RTCC_CAL_YEAR];
  wire [7:0] mon  = {3'b000, calVal[`RTCC_CAL_MON]};
  wire [7:0] date = {2'b00, calVal[`RTCC_CAL_DATE]};
  wire [2:0] dow  = calVal[`RTCC_CAL_DOW];

  // leap year on bcd digits: even tens with 0/4/8, odd tens with 2/6
  wire leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                      : (year[1:0] == 2'b00);

  assign monthLen = (mon == `RTCC_MON_FEB) ? (leap ? `RTCC_LEN_LEAP : `RTCC_LEN_FEB) :
                    (mon == `RTCC_MON_APR || mon == `RTCC_MON_JUN ||
                     mon == `RTCC_MON_SEP || mon == `RTCC_MON_NOV) ? `RTCC_LEN_SHORT : `RTCC_DATE_MAX;

  // hour range follows the mode and the pm indicator
  wire hourOk = hour12 ? inRange(hour, `RTCC_ONE, `RTCC_HR12_MAX)
                       : (inRange(hour, `RTCC_ZERO, `RTCC_HR_MAX) && !pm);

  assign timeOk = hourOk && inRange(min, `RTCC_ZERO, `RTCC_MS_MAX)
                         && inRange(sec, `RTCC_ZERO, `RTCC_MS_MAX);

  wire centOk = persian ? inRange(cent, `RTCC_PCENT_LO, `RTCC_PCENT_HI)
                        : inRange(cent, `RTCC_CENT_LO, `RTCC_CENT_HI);

  assign calOk = centOk && isBcd(year)
              && inRange(date, `RTCC_ONE, `RTCC_DATE_MAX)
              && inRange(mon, `RTCC_ONE, `RTCC_MON_MAX) && (date <= monthLen)
              && (dow >= `RTCC_DOW_MIN) && (dow <= `RTCC_DOW_MAX);

endmodule // rtcc_entry_check

// ---- logic/rtcc_calendar_check.v ----
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rtcc_map.vh"

// ==========================================================
// time and calendar counters with entry check and update handshake
module rtcc_calendar_check #(
  parameter TICK_CYCLES = `RTCC_SEC_MS * `RTCC_NS_PER_MS / `RTCC_CLK_NS
) (
  input  wire        clk,        // 100 mhz clock
  input  wire        rst,        // synchronous reset, active high
  input  wire [7:0]  regAddr,    // register byte address
  input  wire [31:0] regWrData,  // write data
  input  wire        regWr,      // write strobe
  input  wire        regRd,      // read strobe
  output wire [31:0] regRdData,  // read data, cycle after the strobe
  output wire        irq         // interrupt, active high level
);

  // last count of the prescaler; the default gives one second at 100 mhz,
  // simulation passes a short value so seconds come quickly
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // ==========================================================
  // helper functions

  // bcd increment of a two-digit value; a tens digit of 9 steps on to hex a,
  // so callers must catch their own last value before stepping past it
  function [7:0] bcdInc;
    input [7:0] v;
    bcdInc = (v[3:0] == `RTCC_DIGIT_MAX) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // bcd increment that wraps to a first value past the last one
  function [7:0] bcdStep;
    input [7:0] v;
    input [7:0] last;
    input [7:0] first;
    bcdStep = (v == last) ? first : bcdInc(v);
  endfunction

  // 12-hour bcd hour plus pm indicator to 24-hour bcd hour
  // 12 am is midnight and 12 pm is noon; other pm hours add twelve,
  // with an extra digit carry when the units digit is 8 or 9
  function [7:0] to24;
    input [7:0] h;
    input       pm;
    if (h == `RTCC_HR12_MAX)
      to24 = pm ? `RTCC_HR12_MAX : `RTCC_ZERO;
    else if (!pm)
      to24 = h;
    else if (h[3:0] >= `RTCC_PM_UNIT)
      to24 = h + `RTCC_PM_CARRY;
    else
      to24 = h + `RTCC_PM_ADJ;
  endfunction

  // ==========================================================
  // registers

  reg  [1:0]  ctrlReg;
  reg  [1:0]  modeReg;
  reg  [2:0]  ienReg;
  reg  [31:0] timeReg;
  reg  [31:0] calReg;
  reg         ackReg;
  reg         secReg;
  reg         errReg;
  reg         rejReg;
  reg         irqReg;
  reg  [31:0] rdDataReg;
  reg  [31:0] tickCntReg;

  reg  [31:0] timeNext;
  reg  [31:0] calNext;
  reg  [31:0] rdMux;

  // ==========================================================
  // bus decode; addresses are compared whole, so a byte offset
  // inside a word hits nothing and reads back as zero
  wire wrCtrl = regWr && (regAddr == `RTCC_OFF_CTRL);
  wire wrMode = regWr && (regAddr == `RTCC_OFF_MODE);
  wire wrTime = regWr && (regAddr == `RTCC_OFF_TIME);
  wire wrCal  = regWr && (regAddr == `RTCC_OFF_CAL);
  wire wrSclr = regWr && (regAddr == `RTCC_OFF_SCLR);
  wire wrIen  = regWr && (regAddr == `RTCC_OFF_IEN);

  // status clear bits sit at the same positions as the status bits
  wire clrAck = wrSclr && regWrData[`RTCC_ST_ACK];
  wire clrSec = wrSclr && regWrData[`RTCC_ST_SEC];
  wire clrErr = wrSclr && regWrData[`RTCC_ST_DATE_ERR];
  wire clrRej = wrSclr && regWrData[`RTCC_ST_REJECT];

  // ==========================================================
  // update requests and counter gating
  wire timeReq = ctrlReg[`RTCC_CTRL_TIME_REQ];
  wire calReq  = ctrlReg[`RTCC_CTRL_CAL_REQ];
  wire timeRun = !timeReq;
  wire calRun  = !timeReq && !calReq;

  // a request bit going from 0 to 1 is acknowledged on the next edge;
  // rewriting a bit that is already set raises no second acknowledge,
  // and the order of clear and field writes is left to software
  wire ackSet = wrCtrl && ((regWrData[1:0] & ~ctrlReg) != 2'b00);

  // ==========================================================
  // one-second prescaler, free running so the second event keeps
  // its rhythm while counting is stopped
  wire tick = (tickCntReg == TICK_LAST);

  always @(posedge clk) begin
    if (rst)
      tickCntReg <= 32'h00000000;
    else if (tick)
      tickCntReg <= 32'h00000000;
    else
      tickCntReg <= tickCntReg + 32'h00000001;
  end

  // ==========================================================
  // entry check on written words and constant check on counters
  wire       wrTimeOk;
  wire       wrCalOk;
  wire       cntTimeOk;
  wire       cntCalOk;
  wire [7:0] monthLen;

  // the write data are checked as both a time and a calendar word;
  // the address decides which of the two verdicts is used
  rtcc_entry_check wrCheck (
    .timeVal  (regWrData),
    .calVal   (regWrData),
    .hour12   (modeReg[`RTCC_MODE_HR12]),
    .persian  (modeReg[`RTCC_MODE_PERSIAN]),
    .timeOk   (wrTimeOk),
    .calOk    (wrCalOk),
    .monthLen ()
  );

  // counters always hold 24-hour values
  rtcc_entry_check cntCheck (
    .timeVal  (timeReg),
    .calVal   (calReg),
    .hour12   (1'b0),
    .persian  (modeReg[`RTCC_MODE_PERSIAN]),
    .timeOk   (cntTimeOk),
    .calOk    (cntCalOk),
    .monthLen (monthLen)
  );

  // the counters are checked against the current century range, so a
  // mode change alone can make a good calendar bad and the reverse
  wire cntBad = !cntTimeOk || !cntCalOk;

  // writes land only while the matching group is stopped
  // a write outside the handshake is dropped without any status
  wire timeWrAllowed = wrTime && timeReq;
  wire calWrAllowed  = wrCal && calReq;
  wire timeTake = timeWrAllowed && wrTimeOk;
  wire calTake  = calWrAllowed && wrCalOk;
  wire rejSet   = (timeWrAllowed && !wrTimeOk) || (calWrAllowed && !wrCalOk);

  // 12-hour entries are stored as 24-hour values
  wire [7:0] hourIn    = {2'b00, regWrData[`RTCC_TIM_HOUR]};
  wire [7:0] hourStore = modeReg[`RTCC_MODE_HR12] ?
                         to24(hourIn, regWrData[`RTCC_TIM_PM]) : hourIn;
  wire [31:0] timeWrVal = {10'h000, hourStore[5:0], 1'b0,
                           regWrData[`RTCC_TIM_MIN], 1'b0, regWrData[`RTCC_TIM_SEC]};
  wire [31:0] calWrVal  = {2'b00, regWrData[`RTCC_CAL_DATE], regWrData[`RTCC_CAL_DOW],
                           regWrData[`RTCC_CAL_MON], regWrData[`RTCC_CAL_YEAR],
                           1'b0, regWrData[`RTCC_CAL_CENT]};

  // ==========================================================
  // current counter fields
  wire [7:0] secCur  = {1'b0, timeReg[`RTCC_TIM_SEC]};
  wire [7:0] minCur  = {1'b0, timeReg[`RTCC_TIM_MIN]};
  wire [7:0] hourCur = {2'b00, timeReg[`RTCC_TIM_HOUR]};
  wire [7:0] dateCur = {2'b00, calReg[`RTCC_CAL_DATE]};
  wire [7:0] monCur  = {3'b000, calReg[`RTCC_CAL_MON]};
  wire [7:0] yearCur = calReg[`RTCC_CAL_YEAR];
  wire [7:0] centCur = {1'b0, calReg[`RTCC_CAL_CENT]};
  wire [2:0] dowCur  = calReg[`RTCC_CAL_DOW];

  // ==========================================================
  // counting; a stopped calendar drops the day carry of midnight
  // the carry chain only ripples on a tick, so a counter holding a bad
  // value still steps and may roll over into a good one
  reg [7:0] secN;
  reg [7:0] minN;
  reg [7:0] hourN;
  reg [7:0] dateN;
  reg [7:0] monN;
  reg [7:0] yearN;
  reg [7:0] centN;
  reg [2:0] dowN;
  reg       dayCarry;

  always @* begin
    secN     = secCur;
    minN     = minCur;
    hourN    = hourCur;
    dateN    = dateCur;
    monN     = monCur;
    yearN    = yearCur;
    centN    = centCur;
    dowN     = dowCur;
    dayCarry = 1'b0;
    if (tick && timeRun) begin
      secN = bcdStep(secCur, `RTCC_MS_MAX, `RTCC_ZERO);
      if (secCur == `RTCC_MS_MAX) begin
        minN = bcdStep(minCur, `RTCC_MS_MAX, `RTCC_ZERO);
        if (minCur == `RTCC_MS_MAX) begin
          hourN    = bcdStep(hourCur, `RTCC_HR_MAX, `RTCC_ZERO);
          dayCarry = (hourCur == `RTCC_HR_MAX);
        end
      end
    end
    if (dayCarry && calRun) begin
      dowN  = (dowCur == `RTCC_DOW_MAX) ? `RTCC_DOW_MIN : dowCur + 3'h1;
      dateN = bcdStep(dateCur, monthLen, `RTCC_ONE);
      if (dateCur == monthLen) begin
        monN = bcdStep(monCur, `RTCC_MON_MAX, `RTCC_ONE);
        if (monCur == `RTCC_MON_MAX) begin
          yearN = bcdStep(yearCur, `RTCC_YEAR_MAX, `RTCC_ZERO);
          if (yearCur == `RTCC_YEAR_MAX)
            centN = bcdInc(centCur);
        end
      end
    end
  end

  // accepted writes win over counting; rejected ones change nothing
  always @* begin
    if (timeTake)
      timeNext = timeWrVal;
    else
      timeNext = {10'h000, hourN[5:0], 1'b0, minN[6:0], 1'b0, secN[6:0]};
    if (calTake)
      calNext = calWrVal;
    else
      calNext = {2'b00, dateN[5:0], dowN, monN[4:0], yearN, 1'b0, centN[6:0]};
  end

  // ==========================================================
  // control, mode and enable registers plus the counters
  // unused upper bits of these registers are dropped on write
  always @(posedge clk) begin
    if (rst) begin
      ctrlReg <= 2'h0;
      modeReg <= 2'h0;
      ienReg  <= 3'h0;
      timeReg <= `RTCC_TIME_RST;
      calReg  <= `RTCC_CAL_RST;
    end else begin
      if (wrCtrl)
        ctrlReg <= regWrData[1:0];
      if (wrMode)
        modeReg <= regWrData[1:0];
      if (wrIen)
        ienReg <= regWrData[2:0];
      timeReg <= timeNext;
      calReg  <= calNext;
    end
  end

  // ==========================================================
  // sticky status flags; a set in the clearing cycle wins
  always @(posedge clk) begin
    if (rst) begin
      ackReg <= 1'b0;
      secReg <= 1'b0;
      errReg <= 1'b0;
      rejReg <= 1'b0;
    end else begin
      ackReg <= ackSet || (ackReg && !clrAck);
      secReg <= tick || (secReg && !clrSec);
      // the bad value keeps setting the flag, so a clear only sticks
      // once the counters are good again; roll-over alone never clears
      errReg <= cntBad || (errReg && !clrErr);
      rejReg <= rejSet || (rejReg && !clrRej);
    end
  end

  // ==========================================================
  // interrupt, registered so the output never glitches
  // this costs one cycle of latency behind the flags
  always @(posedge clk) begin
    if (rst)
      irqReg <= 1'b0;
    else
      irqReg <= |({errReg, secReg, ackReg} & ienReg);
  end

  // ==========================================================
  // read mux; the status clear register is write only
  always @* begin
    case (regAddr)
      `RTCC_OFF_CTRL: rdMux = {30'h0, ctrlReg};
      `RTCC_OFF_MODE: rdMux = {30'h0, modeReg};
      `RTCC_OFF_TIME: rdMux = timeReg;
      `RTCC_OFF_CAL:  rdMux = calReg;
      `RTCC_OFF_STAT: rdMux = {28'h0000000, rejReg, errReg, secReg, ackReg};
      `RTCC_OFF_IEN:  rdMux = {29'h0, ienReg};
      default:        rdMux = 32'h00000000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  // zero between reads keeps stale status from looking like a fresh answer
  always @(posedge clk) begin
    if (rst)
      rdDataReg <= 32'h00000000;
    else if (regRd)
      rdDataReg <= rdMux;
    else
      rdDataReg <= 32'h00000000;
  end

  assign regRdData = rdDataReg;
  assign irq       = irqReg;

endmodule // rtcc_calendar_check

// ---- testbench/rtcc_calendar_check_checker.sv ----
`timescale 1ns/1ps
`include "rtcc_map.vh"

// ==========================================================
// port checks of the register bus, handshake and interrupt
module rtcc_calendar_check_checker (
  input wire        clk,        // clock
  input wire        rst,        // synchronous reset
  input wire [7:0]  regAddr,    // byte address
  input wire [31:0] regWrData,  // write data
  input wire        regWr,      // write strobe
  input wire        regRd,      // read strobe
  input wire [31:0] regRdData,  // read data
  input wire        irq         // interrupt level
);
  reg  [1:0] ctrlReg;   // shadow of request bits
  reg  [1:0] modeReg;   // shadow of mode bits
  reg  [2:0] ienReg;    // shadow of enables
  reg  [1:0] ackPipe;   // request raised, settling
  reg        ackDue;    // acknowledge must be visible
  wire       ctrlWr = regWr && regAddr == `RTCC_OFF_CTRL;
  wire       reqUp  = ctrlWr && |(regWrData[1:0] & ~ctrlReg);
  wire       stRd   = regRd && regAddr == `RTCC_OFF_STAT;

  // shadows; the ack gets two edges of slack so either latency passes
  always @(posedge clk) begin
    if (rst) begin
      ctrlReg <= 2'h0;
      modeReg <= 2'h0;
      ienReg  <= 3'h0;
      ackPipe <= 2'h0;
      ackDue  <= 1'b0;
    end else begin
      if (ctrlWr) ctrlReg <= regWrData[1:0];
      if (regWr && regAddr == `RTCC_OFF_MODE) modeReg <= regWrData[1:0];
      if (regWr && regAddr == `RTCC_OFF_IEN) ienReg <= regWrData[2:0];
      ackPipe <= {ackPipe[0], reqUp};
      ackDue  <= ackDue | ackPipe[1];
      if (regWr && regAddr == `RTCC_OFF_SCLR && regWrData[0]) ackDue <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // assertions
  a_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (regRd && (regAddr > `RTCC_OFF_IEN || regAddr == `RTCC_OFF_SCLR)
    |=> regRdData == 32'h0) else $error("unmapped or clear register read nonzero");
  a_time_24h_form: assert property (
    regRd && regAddr == `RTCC_OFF_TIME |=> !regRdData[22] && regRdData[21:16] <= 6'h23)
    else $error("time read not in 24-hour form");
  a_ctrl_readback: assert property (
    regRd && regAddr == `RTCC_OFF_CTRL |=> regRdData[1:0] == $past(ctrlReg))
    else $error("request bits read back wrong");
  a_mode_readback: assert property (regRd && regAddr == `RTCC_OFF_MODE |=> regRdData[1:0] == $past(modeReg))
    else $error("mode bits read back wrong");
  a_ien_readback: assert property (regRd && regAddr == `RTCC_OFF_IEN |=> regRdData[2:0] == $past(ienReg))
    else $error("enable bits read back wrong");
  a_ack_raised: assert property (ackDue && stRd |=> regRdData[0])
    else $error("update acknowledge missing after request");
  a_irq_masked: assert property (ienReg == 3'h0 && $past(ienReg) == 3'h0 |-> !irq)
    else $error("interrupt with all enables off");
  a_irq_source: assert property (irq |-> |$past(ienReg))
    else $error("interrupt without an enable");

  // ==========================================================
  // coverage of the main scenarios
  c_ack_seen: cover property (ackDue && stRd ##1 regRdData[0]);
  c_err_seen: cover property (stRd ##1 regRdData[2]);
  c_irq_seen: cover property ($rose(irq));
endmodule // rtcc_calendar_check_checker

bind rtcc_calendar_check rtcc_calendar_check_checker u_chk (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));

// ---- testbench/rtcc_calendar_check_tb.sv ----
`timescale 1ns/1ps

// ==========================================================
// register-level bench of the calendar check block
module rtcc_calendar_check_tb;
  localparam int TICK = 40;  // short second keeps the run brief
  reg          clk = 1'b0;
  reg          rst = 1'b1;
  reg  [7:0]   regAddr = 8'h00;
  reg  [31:0]  regWrData = 32'h0;
  reg          regWr = 1'b0;
  reg          regRd = 1'b0;
  wire [31:0]  regRdData;
  wire         irq;
  int          err_total = 0;
  int          checked = 0;
  logic [31:0] rdv;
  logic [31:0] g;

  rtcc_calendar_check #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));

  // free-running clock
  always #5 clk = ~clk;

  // ==========================================================
  // bus tasks and compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rdv);
    chk(rdv & m, e);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for one status bit
  task automatic poll(input int b);
    int n;
    n = 0;
    rd(8'h10, rdv);
    while (rdv[b] !== 1'b1 && n < 4 * TICK) begin
      rd(8'h10, rdv);
      n++;
    end
    chk({31'h0, rdv[b]}, 32'h1);
    if (rdv[b] !== 1'b1) finish_test();
  endtask
  // stop counting and take the acknowledge
  task automatic upd_start(input logic [1:0] r);
    wr(8'h00, {30'h0, r});
    poll(0);
    wr(8'h14, 32'h1);
    rdc(8'h10, 32'h1, 32'h0);
  endtask
  // resume, clear the second flag, wait a second before any new update
  task automatic upd_end;
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h2);
    poll(1);
  endtask
  // one entry: mode, write, readback, reject status
  task automatic ent(input logic [7:0] a, input logic [1:0] m, input logic [31:0] w,
                     input logic [31:0] e, input logic j);
    wr(8'h04, {30'h0, m});
    wr(8'h14, 32'h8);
    wr(a, w);
    rdc(a, 32'hffffffff, e);
    rdc(8'h10, 32'h8, {28'h0, j, 3'h0});
  endtask
  function automatic logic [31:0] cw(input logic [7:0] c, input logic [7:0] y, input logic [7:0] m,
                                     input logic [2:0] w, input logic [7:0] d);
    cw = {2'b00, d[5:0], w, m[4:0], y, 1'b0, c[6:0]};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped place ignored
    rdc(8'h00, 32'hffffffff, 32'h0);
    rdc(8'h04, 32'hffffffff, 32'h0);
    rdc(8'h0c, 32'hffffffff, 32'h01c10020);
    rdc(8'h10, 32'hd, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rdc(8'h1c, 32'hffffffff, 32'h0);
    $display("test reset done");
    // handshake with acknowledge interrupt; values written after the acknowledge
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h3);
    poll(0);
    chk({31'h0, irq}, 32'h1);
    wr(8'h14, 32'h1);
    rdc(8'h10, 32'h1, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h18, 32'h0);
    // time entries in both hour modes
    ent(8'h08, 2'h0, 32'h00235959, 32'h00235959, 1'b0);
    ent(8'h08, 2'h0, 32'h00240000, 32'h00235959, 1'b1);
    ent(8'h08, 2'h0, 32'h00400000, 32'h00235959, 1'b1);
    ent(8'h08, 2'h0, 32'h00006000, 32'h00235959, 1'b1);
    ent(8'h08, 2'h0, 32'h0000005a, 32'h00235959, 1'b1);
    ent(8'h08, 2'h1, 32'h00120000, 32'h00000000, 1'b0);
    ent(8'h08, 2'h1, 32'h00521510, 32'h00121510, 1'b0);
    ent(8'h08, 2'h1, 32'h00470000, 32'h00190000, 1'b0);
    ent(8'h08, 2'h1, 32'h00110000, 32'h00110000, 1'b0);
    ent(8'h08, 2'h1, 32'h00130000, 32'h00110000, 1'b1);
    ent(8'h08, 2'h1, 32'h00400000, 32'h00110000, 1'b1);
    // both counters stand under a time request
    repeat (3 * TICK) @(posedge clk);
    rdc(8'h08, 32'hffffffff, 32'h00110000);
    $display("test time entry done");
    // calendar entries
    g = cw(8'h20, 8'h24, 8'h06, 3'h3, 8'h15);
    ent(8'h0c, 2'h0, g, g, 1'b0);
    rdc(8'h0c, 32'hffffffff, g);
    ent(8'h0c, 2'h0, cw(8'h20, 8'h9a, 8'h06, 3'h3, 8'h15), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h21, 8'h24, 8'h06, 3'h3, 8'h15), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h18, 8'h24, 8'h06, 3'h3, 8'h15), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h20, 8'h24, 8'h06, 3'h3, 8'h00), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h20, 8'h24, 8'h06, 3'h3, 8'h32), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h20, 8'h24, 8'h13, 3'h3, 8'h15), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h20, 8'h24, 8'h00, 3'h3, 8'h15), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h20, 8'h24, 8'h04, 3'h3, 8'h31), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h20, 8'h23, 8'h02, 3'h3, 8'h29), g, 1'b1);
    ent(8'h0c, 2'h0, cw(8'h19, 8'h24, 8'h02, 3'h0, 8'h29), g, 1'b1);
    g = cw(8'h19, 8'h24, 8'h02, 3'h7, 8'h29);
    ent(8'h0c, 2'h0, g, g, 1'b0);
    g = cw(8'h14, 8'h24, 8'h02, 3'h7, 8'h29);
    ent(8'h0c, 2'h2, g, g, 1'b0);
    upd_end();
    $display("test calendar entry done");
    // error flag: set, refused clear, sticky after cure, interrupt
    wr(8'h14, 32'h4);
    rdc(8'h10, 32'h4, 32'h0);
    wr(8'h18, 32'h4);
    wr(8'h04, 32'h0);
    rdc(8'h10, 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(8'h14, 32'h4);
    rdc(8'h10, 32'h4, 32'h4);
    wr(8'h04, 32'h2);
    rdc(8'h10, 32'h4, 32'h4);
    wr(8'h14, 32'h4);
    rdc(8'h10, 32'h4, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // cure by a calendar rewrite while time keeps counting
    wr(8'h04, 32'h0);
    upd_start(2'h2);
    rd(8'h08, g);
    repeat (2 * TICK + 4) @(posedge clk);
    rd(8'h08, rdv);
    chk({31'h0, rdv === g}, 32'h0);
    wr(8'h08, 32'h00010203);
    rd(8'h08, rdv);
    chk({31'h0, rdv === 32'h00010203}, 32'h0);
    g = cw(8'h20, 8'h24, 8'h02, 3'h7, 8'h29);
    wr(8'h0c, g);
    rdc(8'h0c, 32'hffffffff, g);
    wr(8'h14, 32'h4);
    rdc(8'h10, 32'h4, 32'h0);
    upd_end();
    $display("test error flag done");
    // second event interrupt
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h2);
    poll(1);
    chk({31'h0, irq}, 32'h1);
    wr(8'h18, 32'h0);
    $display("test second event done");
    finish_test();
  end
endmodule // rtcc_calendar_check_tb
